// >>> hw/iasc_top.sv
// address size and attribute checks with their apb register file
`timescale 1ns/1ps
`default_nettype none
module iasc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic        pready,
  output var  logic [31:0] prdata,
  output var  logic        pslverr,
  // upstream transaction
  input  wire logic        req_valid,
  input  wire logic [48:0] req_addr,
  input  wire logic        req_instr,
  input  wire logic        req_transient,
  input  wire logic        req_ns,
  input  wire logic        req_walk,
  input  wire logic        req_cmo,
  input  wire logic        req_unpriv,
  input  wire logic [7:0]  req_attr,
  // downstream result
  output logic             rsp_valid_ff,
  output logic [47:0]      rsp_addr_ff,
  output logic             rsp_fault_ff,
  output logic [2:0]       rsp_fault_code_ff,
  output logic [7:0]       rsp_attr_ff,
  output logic             rsp_transient_ff,
  output logic             rsp_instr_ff,
  output logic [7:0]       rsp_mcid_ff,
  output logic             rsp_walk_ns_ff,
  output logic [1:0]       rsp_stages_ff
);

  // registers
  logic [8:0]  ctx_cfg_ff;
  logic [2:0]  s2cr_ff;
  logic [15:0] cbar_ff;
  logic [9:0]  tcr_ff;
  logic [6:0]  tcr2_ff;
  logic [3:0]  tlb_vld_ff;
  logic [3:0]  tlb_sec_ff;
  logic [3:0]  tlb_hyp_ff;
  logic [1:0]  tlb_ptr_ff;
  logic [2:0]  last_flt_ff;

  // apb decode
  wire logic apb_acc  = psel & penable;
  wire logic apb_wr   = apb_acc & pready & pwrite;
  wire logic hit_id   = paddr == iasc_pkg::OFS_SIZE_ID;
  wire logic hit_ctx  = paddr == iasc_pkg::OFS_CTX;
  wire logic hit_s2cr = paddr == iasc_pkg::OFS_S2CR;
  wire logic hit_cbar = paddr == iasc_pkg::OFS_CBAR;
  wire logic hit_tcr  = paddr == iasc_pkg::OFS_TCR;
  wire logic hit_tcr2 = paddr == iasc_pkg::OFS_TCR2;
  wire logic hit_tlb  = paddr == iasc_pkg::OFS_TLB;
  wire logic hit_stat = paddr == iasc_pkg::OFS_STAT;
  wire logic hit_any  = hit_id | hit_ctx | hit_s2cr | hit_cbar | hit_tcr | hit_tcr2 |
                        hit_tlb | hit_stat;

  wire logic [31:0] stat_val = {17'h00000, tlb_hyp_ff, tlb_sec_ff, tlb_vld_ff, last_flt_ff};
  wire logic [31:0] rd_mux   = hit_id   ? iasc_pkg::SIZE_ID_VAL :
                               hit_ctx  ? {23'h000000, ctx_cfg_ff} :
                               hit_s2cr ? {29'h00000000, s2cr_ff} :
                               hit_cbar ? {16'h0000, cbar_ff} :
                               hit_tcr  ? {22'h000000, tcr_ff} :
                               hit_tcr2 ? {25'h0000000, tcr2_ff} :
                               hit_stat ? stat_val : 32'h00000000;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_acc & ~pready;
      prdata  <= (apb_acc & ~pready & ~pwrite) ? rd_mux : 32'h00000000;
      pslverr <= apb_acc & ~pready & ~hit_any;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctx_cfg_ff <= iasc_pkg::CC_RST;
      s2cr_ff    <= iasc_pkg::SC_RST;
      cbar_ff    <= iasc_pkg::CB_RST;
      tcr_ff     <= iasc_pkg::TC_RST;
      tcr2_ff    <= iasc_pkg::T2_RST;
    end else begin
      if (apb_wr & hit_ctx) begin
        ctx_cfg_ff <= pwdata[8:0];
      end
      if (apb_wr & hit_s2cr) begin
        s2cr_ff <= pwdata[2:0];
      end
      if (apb_wr & hit_cbar) begin
        cbar_ff <= pwdata[15:0];
      end
      if (apb_wr & hit_tcr) begin
        tcr_ff <= pwdata[9:0];
      end
      if (apb_wr & hit_tcr2) begin
        tcr2_ff <= pwdata[6:0];
      end
    end
  end

  // configuration fields
  iasc_pkg::iasc_ctx_t ctx_type;
  assign ctx_type = iasc_pkg::iasc_ctx_t'(ctx_cfg_ff[iasc_pkg::CC_TYPE +: 2]);
  wire logic       ctx_hyp   = ctx_cfg_ff[iasc_pkg::CC_HYP];
  wire logic       ctx_sec   = ctx_cfg_ff[iasc_pkg::CC_SEC];
  wire logic       ctx_short = ctx_cfg_ff[iasc_pkg::CC_SHORT];
  wire logic       ctx_va64  = ctx_cfg_ff[iasc_pkg::CC_VA64];
  wire logic       ctx_en    = ctx_cfg_ff[iasc_pkg::CC_EN];
  wire logic       ctx_ucm   = ctx_cfg_ff[iasc_pkg::CC_UCM];
  wire logic       ctx_sfc   = ctx_cfg_ff[iasc_pkg::CC_SFC];
  wire logic       instr_ovr = s2cr_ff[iasc_pkg::SC_INSTOVR];
  wire logic [7:0] cb_attr   = cbar_ff[iasc_pkg::CB_ATTR +: 8];
  wire logic [7:0] cb_mcid   = cbar_ff[iasc_pkg::CB_MCID +: 8];
  wire logic [1:0] gran      = tcr_ff[iasc_pkg::TC_GRAN +: 2];
  wire logic       is_s1byp  = ctx_type == iasc_pkg::CTX_S1_BYP;
  wire logic       is_ipa    = ctx_type == iasc_pkg::CTX_IPA_S2;
  wire logic       is_s1     = is_s1byp | (ctx_type == iasc_pkg::CTX_NESTED);
  wire logic       translating = ctx_en & (ctx_type != iasc_pkg::CTX_BYPASS);

  // limits
  // register width selects range
  wire logic [5:0] va_lim  = ctx_va64 ? iasc_pkg::UPW_RPT :
                             iasc_pkg::min6(iasc_pkg::UPW_RPT, iasc_pkg::VA32_BITS);
  wire logic [5:0] ipa_lim = is_s1byp ?
                             iasc_pkg::min6(iasc_pkg::IPW_RPT, iasc_pkg::OPW_RPT) :
                             iasc_pkg::IPW_RPT;
  wire logic [5:0] pa_src  = is_ipa ? tcr_ff[iasc_pkg::TC_PA +: 6] : tcr2_ff[iasc_pkg::T2_PA +: 6];
  wire logic [5:0] pa_lim  = iasc_pkg::min6(iasc_pkg::OPW_RPT, pa_src);

  iasc_chk_if ck ();

  assign ck.addr    = req_addr;
  assign ck.va_lim  = va_lim;
  assign ck.ipa_lim = ipa_lim;
  assign ck.pa_lim  = pa_lim;

  iasc_addr_chk u_chk (
    .ck (ck)
  );

  // fault terms
  // instruction override
  wire logic instr_eff = req_instr & ~instr_ovr;
  wire logic sfc_hit   = ctx_sfc & ctx_sec & instr_eff & req_ns;
  wire logic cmo_flt   = req_cmo & req_unpriv & ~ctx_ucm;
  wire logic va_flt    = translating & ~is_ipa & ck.over_va;
  // base 0 walks disabled, hypervisor too
  wire logic sel_base1 = ctx_va64 & req_addr[48];
  wire logic wd_flt    = translating & is_s1 & tcr_ff[iasc_pkg::TC_WD0] & ~sel_base1;
  wire logic gran_flt  = translating & ~iasc_pkg::GRAN_SUPP[gran];
  wire logic ipa_flt   = translating & ck.over_ipa;
  wire logic pa_flt    = translating & ck.over_pa;

  wire logic [2:0] flt_code = cmo_flt  ? iasc_pkg::FLT_CMO :
                              va_flt   ? iasc_pkg::FLT_VA :
                              wd_flt   ? iasc_pkg::FLT_WALK :
                              gran_flt ? iasc_pkg::FLT_GRAN :
                              ipa_flt  ? iasc_pkg::FLT_IPA :
                              pa_flt   ? iasc_pkg::FLT_PA :
                              sfc_hit  ? iasc_pkg::FLT_SFC : iasc_pkg::FLT_NONE;
  wire logic       flt_any  = flt_code != iasc_pkg::FLT_NONE;

  // result fields
  // bypass truncation
  wire logic [47:0] nxt_addr = flt_any ? 48'h000000000000 :
                               translating ? req_addr[47:0] :
                               req_addr[47:0] & iasc_pkg::OPW_MASK;
  wire logic [7:0] nxt_attr  = (translating & is_s1byp) ? cb_attr : req_attr;
  wire logic nxt_trans = ctx_short & (s2cr_ff[iasc_pkg::SC_TROVR] ?
                                      s2cr_ff[iasc_pkg::SC_TRVAL] : req_transient);
  wire logic [7:0] nxt_mcid  = (~ctx_sec & ~ctx_hyp & (ctx_type != iasc_pkg::CTX_BYPASS)) ?
                               cb_mcid : 8'h00;
  // walk security from tcr or tcr2
  wire logic walk_cfg = ctx_va64 ? tcr2_ff[iasc_pkg::T2_NSCFG] : tcr_ff[iasc_pkg::TC_NSCFG];
  wire logic nxt_wns  = req_walk ? (ctx_sec ? walk_cfg : 1'b1) : req_ns;
  // ipa space is stage 2 alone
  wire logic [1:0] nxt_stg = ~translating ? iasc_pkg::STG_NONE :
                             is_ipa   ? iasc_pkg::STG_S2 :
                             is_s1byp ? iasc_pkg::STG_S1 : iasc_pkg::STG_BOTH;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_ff      <= 1'b0;
      rsp_fault_ff      <= 1'b0;
      rsp_fault_code_ff <= iasc_pkg::FLT_NONE;
      rsp_addr_ff       <= 48'h000000000000;
      rsp_attr_ff       <= 8'h00;
      rsp_transient_ff  <= 1'b0;
    end else begin
      rsp_valid_ff      <= req_valid;
      rsp_fault_ff      <= req_valid & flt_any;
      rsp_fault_code_ff <= req_valid ? flt_code : iasc_pkg::FLT_NONE;
      rsp_addr_ff       <= nxt_addr;
      rsp_attr_ff       <= nxt_attr;
      rsp_transient_ff  <= nxt_trans;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_instr_ff   <= 1'b0;
      rsp_mcid_ff    <= 8'h00;
      rsp_walk_ns_ff <= 1'b0;
      rsp_stages_ff  <= iasc_pkg::STG_NONE;
    end else begin
      rsp_instr_ff   <= instr_eff;
      rsp_mcid_ff    <= nxt_mcid;
      rsp_walk_ns_ff <= nxt_wns;
      rsp_stages_ff  <= nxt_stg;
    end
  end

  // tlb entry tags: allocation wins over a same-cycle invalidate
  wire logic       stlb_inv = apb_wr & hit_tlb & pwdata[iasc_pkg::TLB_INV];
  wire logic       alloc    = req_valid & translating & ~flt_any;
  wire logic [3:0] alloc_oh = alloc ? (4'h1 << tlb_ptr_ff) : 4'h0;
  wire logic [3:0] inv_mask = stlb_inv ?
                              (tlb_sec_ff & (iasc_pkg::INV_SEC_HYP ? 4'hf : ~tlb_hyp_ff)) :
                              4'h0;
  wire logic [3:0] nxt_vld  = (tlb_vld_ff & ~inv_mask) | alloc_oh;
  wire logic [3:0] nxt_sec  = (tlb_sec_ff & ~alloc_oh) | (ctx_sec ? alloc_oh : 4'h0);
  wire logic [3:0] nxt_hyp  = (tlb_hyp_ff & ~alloc_oh) | (ctx_hyp ? alloc_oh : 4'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tlb_vld_ff  <= 4'h0;
      tlb_sec_ff  <= 4'h0;
      tlb_hyp_ff  <= 4'h0;
      tlb_ptr_ff  <= 2'h0;
      last_flt_ff <= iasc_pkg::FLT_NONE;
    end else begin
      tlb_vld_ff  <= nxt_vld;
      tlb_sec_ff  <= nxt_sec;
      tlb_hyp_ff  <= nxt_hyp;
      tlb_ptr_ff  <= tlb_ptr_ff + {1'b0, alloc};
      last_flt_ff <= req_valid ? flt_code : last_flt_ff;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_transient_hint: assert property (
    req_valid && ctx_short && s2cr_ff[iasc_pkg::SC_TROVR]
    |=> rsp_transient_ff == $past(s2cr_ff[iasc_pkg::SC_TRVAL]))
    else $error("transient hint not taken from override");

  chk_walk_disable: assert property (
    req_valid && ctx_hyp && translating && is_s1 && tcr_ff[iasc_pkg::TC_WD0] && !req_addr[48]
    && !cmo_flt && !va_flt |=> rsp_fault_ff && rsp_fault_code_ff == iasc_pkg::FLT_WALK)
    else $error("walk disable ignored");

  chk_walk_ns_cfg: assert property (
    req_valid && req_walk && ctx_hyp && ctx_sec |=> rsp_walk_ns_ff == $past(walk_cfg))
    else $error("walk security not from control register");

  chk_bypass_attr: assert property (
    req_valid && translating && is_s1byp |=> rsp_attr_ff == $past(cb_attr))
    else $error("stage 2 attributes not from bank register");

  chk_mcid_carry: assert property (
    req_valid && !ctx_sec && !ctx_hyp && is_s1byp |=> rsp_mcid_ff == $past(cb_mcid))
    else $error("identifier dropped in bypass bank");

  chk_ipa_stage: assert property (
    req_valid && ctx_en && is_ipa |=> rsp_stages_ff == iasc_pkg::STG_S2)
    else $error("ipa space did not run stage 2 alone");

  chk_instr_ovr: assert property (
    req_valid && req_instr && instr_ovr |=> !rsp_instr_ff)
    else $error("instruction override not applied");

  chk_sif_order: assert property (
    rsp_valid_ff && rsp_fault_code_ff == iasc_pkg::FLT_SFC |-> rsp_instr_ff && !$past(instr_ovr))
    else $error("secure fetch fault on overridden access");

  chk_cmo_any: assert property (
    req_valid && req_cmo && req_unpriv && !ctx_ucm
    |=> rsp_fault_ff && rsp_fault_code_ff == iasc_pkg::FLT_CMO)
    else $error("unprivileged maintenance not refused");

  chk_stlb_clear: assert property (
    stlb_inv && !alloc |=> (tlb_vld_ff & tlb_sec_ff & ~tlb_hyp_ff) == 4'h0)
    else $error("secure entry survived invalidate");

  chk_ipa_fault: assert property (
    req_valid && translating && (req_addr >> iasc_pkg::IPW_RPT) != 49'h0 |=> rsp_fault_ff)
    else $error("ipa size fault missing");

  chk_pa_fault: assert property (
    req_valid && translating && (req_addr >> iasc_pkg::OPW_RPT) != 49'h0 |=> rsp_fault_ff)
    else $error("pa size fault missing");

  chk_bypass_trunc: assert property (
    req_valid && !translating && !cmo_flt && !sfc_hit
    |=> !rsp_fault_ff && rsp_addr_ff == ($past(req_addr[47:0]) & iasc_pkg::OPW_MASK))
    else $error("bypass address not truncated");

  cov_s1byp_ok: cover property (req_valid && translating && is_s1byp ##1 !rsp_fault_ff);
  cov_bypass:   cover property (req_valid && !translating ##1 rsp_valid_ff);
  cov_stlb_inv: cover property ((tlb_vld_ff & tlb_sec_ff) != 4'h0 && stlb_inv);
  cov_sfc:      cover property (rsp_fault_code_ff == iasc_pkg::FLT_SFC);

endmodule
`default_nettype wire

// >>> hw/iasc_pkg.sv
// shared constants, register map and field layout of the address size checks
package iasc_pkg;

  // implementation address widths, in bits
  localparam logic [5:0]  UPW_BITS    = 6'h31;
  localparam logic [5:0]  IPW_BITS    = 6'h28;
  localparam logic [5:0]  OPW_BITS    = 6'h28;
  localparam logic [5:0]  VA32_BITS   = 6'h20;
  localparam logic [5:0]  ADDR_MAX    = 6'h30;
  localparam logic        S1_SUPP     = 1'b1;
  localparam logic        S2_SUPP     = 1'b1;
  // bit g set when granule g (0 4KB, 1 16KB, 2 64KB) is built in
  localparam logic [3:0]  GRAN_SUPP   = 4'h5;
  // secure invalidate-all also drops secure hypervisor entries
  localparam logic        INV_SEC_HYP = 1'b1;

  localparam logic [5:0]  IPW_CAP     = (IPW_BITS > ADDR_MAX) ? ADDR_MAX : IPW_BITS;
  localparam logic [5:0]  OPW_CAP     = (OPW_BITS > ADDR_MAX) ? ADDR_MAX : OPW_BITS;
  localparam logic [5:0]  IPW_RPT     = S2_SUPP ? IPW_CAP : OPW_CAP;
  localparam logic [5:0]  OPW_RPT     = OPW_CAP;
  localparam logic [5:0]  UPW_RPT     = S1_SUPP ? UPW_BITS : IPW_RPT;
  localparam logic [31:0] SIZE_ID_VAL = {9'h000, GRAN_SUPP[2:0], S2_SUPP, S1_SUPP,
                                         OPW_RPT, IPW_RPT, UPW_RPT};
  localparam logic [47:0] OPW_MASK    = 48'hffffffffffff >> (ADDR_MAX - OPW_RPT);

  // register byte offsets
  localparam logic [11:0] OFS_SIZE_ID = 12'h000;
  localparam logic [11:0] OFS_CTX     = 12'h004;
  localparam logic [11:0] OFS_S2CR    = 12'h008;
  localparam logic [11:0] OFS_CBAR    = 12'h00c;
  localparam logic [11:0] OFS_TCR     = 12'h010;
  localparam logic [11:0] OFS_TCR2    = 12'h014;
  localparam logic [11:0] OFS_TLB     = 12'h018;
  localparam logic [11:0] OFS_STAT    = 12'h01c;

  // field positions
  localparam int unsigned CC_TYPE     = 0;
  localparam int unsigned CC_HYP      = 2;
  localparam int unsigned CC_SEC      = 3;
  localparam int unsigned CC_SHORT    = 4;
  localparam int unsigned CC_VA64     = 5;
  localparam int unsigned CC_EN       = 6;
  localparam int unsigned CC_UCM      = 7;
  localparam int unsigned CC_SFC      = 8;
  localparam int unsigned SC_INSTOVR  = 0;
  localparam int unsigned SC_TROVR    = 1;
  localparam int unsigned SC_TRVAL    = 2;
  localparam int unsigned CB_ATTR     = 0;
  localparam int unsigned CB_MCID     = 8;
  localparam int unsigned TC_WD0      = 0;
  localparam int unsigned TC_NSCFG    = 1;
  localparam int unsigned TC_PA       = 2;
  localparam int unsigned TC_GRAN     = 8;
  localparam int unsigned T2_NSCFG    = 0;
  localparam int unsigned T2_PA       = 1;
  localparam int unsigned TLB_INV     = 0;

  // reset values
  localparam logic [8:0]  CC_RST      = 9'h000;
  localparam logic [2:0]  SC_RST      = 3'h0;
  localparam logic [15:0] CB_RST      = 16'h0000;
  localparam logic [9:0]  TC_RST      = 10'h0c0;
  localparam logic [6:0]  T2_RST      = 7'h60;

  // fault codes, lowest number wins
  localparam logic [2:0]  FLT_NONE    = 3'h0;
  localparam logic [2:0]  FLT_CMO     = 3'h1;
  localparam logic [2:0]  FLT_VA      = 3'h2;
  localparam logic [2:0]  FLT_WALK    = 3'h3;
  localparam logic [2:0]  FLT_GRAN    = 3'h4;
  localparam logic [2:0]  FLT_IPA     = 3'h5;
  localparam logic [2:0]  FLT_PA      = 3'h6;
  localparam logic [2:0]  FLT_SFC     = 3'h7;

  // stages performed: bit0 stage 1, bit1 stage 2
  localparam logic [1:0]  STG_NONE    = 2'h0;
  localparam logic [1:0]  STG_S1      = 2'h1;
  localparam logic [1:0]  STG_S2      = 2'h2;
  localparam logic [1:0]  STG_BOTH    = 2'h3;

  typedef enum logic [1:0] {CTX_S1_BYP, CTX_NESTED, CTX_IPA_S2, CTX_BYPASS} iasc_ctx_t;

  function automatic logic [5:0] min6(input logic [5:0] a, input logic [5:0] b);
    min6 = (a < b) ? a : b;
  endfunction

endpackage

// >>> hw/iasc_chk_if.sv
// address and width limits passed to the width checker
`timescale 1ns/1ps
`default_nettype none
interface iasc_chk_if;
  logic [48:0] addr;
  logic [5:0]  va_lim;
  logic [5:0]  ipa_lim;
  logic [5:0]  pa_lim;
  logic        over_va;
  logic        over_ipa;
  logic        over_pa;
  modport chk  (input addr, va_lim, ipa_lim, pa_lim, output over_va, over_ipa, over_pa);
  modport user (output addr, va_lim, ipa_lim, pa_lim, input over_va, over_ipa, over_pa);
endinterface
`default_nettype wire

// >>> hw/iasc_addr_chk.sv
// address width checker for the upstream, intermediate and output stages
`timescale 1ns/1ps
`default_nettype none
module iasc_addr_chk (
  // limits and results
  iasc_chk_if.chk ck
);

  function automatic logic exceeds(input logic [48:0] a, input logic [5:0] w);
    exceeds = (a >> w) != 49'h0;
  endfunction

  assign ck.over_va  = exceeds(ck.addr, ck.va_lim);
  assign ck.over_ipa = exceeds(ck.addr, ck.ipa_lim);
  assign ck.over_pa  = exceeds(ck.addr, ck.pa_lim);

endmodule
`default_nettype wire

// >>> verif/iasc_up_model.sv
// upstream bus master model issuing one transaction per command pulse
`timescale 1ns/1ps
`default_nettype none
module iasc_up_model (
  // clock, reset and command from the bench
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [62:0] d,
  // transaction towards the device
  output logic             valid_ff,
  output logic [48:0]      addr_ff,
  output logic [5:0]       flags_ff,
  output logic [7:0]       attr_ff
);
  // between transactions fields toggle so that no stale value looks valid
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_ff <= 1'b0;
      {attr_ff, flags_ff, addr_ff} <= '0;
    end else if (go) begin
      valid_ff <= 1'b1;
      {attr_ff, flags_ff, addr_ff} <= d;
    end else begin
      valid_ff <= 1'b0;
      {attr_ff, flags_ff, addr_ff} <= ~{attr_ff, flags_ff, addr_ff};
    end
  end
endmodule
`default_nettype wire

// >>> verif/iasc_top_test.sv
// self-checking bench for the address size checks
`timescale 1ns/1ps
`default_nettype none
module iasc_top_test;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        go = 1'b0, pready, pslverr, req_valid, vld, flt, trn, ins, wns, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'hf356313a;
  logic [62:0] d = '0;
  logic [48:0] req_addr, a;
  logic [47:0] addr;
  logic [7:0]  req_attr, attr, mcid;
  logic [5:0]  fl;
  logic [2:0]  code;
  logic [1:0]  stg;
  logic [15:0] cb;
  int          n_mismatch = 0;
  int          checked = 0;

  always #2.5 clk = ~clk;

  iasc_up_model UP (.clk(clk), .rst_n(rst_n), .go(go), .d(d), .valid_ff(req_valid),
    .addr_ff(req_addr), .flags_ff(fl), .attr_ff(req_attr));
  iasc_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .req_valid(req_valid), .req_addr(req_addr), .req_instr(fl[0]), .req_transient(fl[1]),
    .req_ns(fl[2]), .req_walk(fl[3]), .req_cmo(fl[4]), .req_unpriv(fl[5]),
    .req_attr(req_attr), .rsp_valid_ff(vld), .rsp_addr_ff(addr), .rsp_fault_ff(flt),
    .rsp_fault_code_ff(code), .rsp_attr_ff(attr), .rsp_transient_ff(trn),
    .rsp_instr_ff(ins), .rsp_mcid_ff(mcid), .rsp_walk_ns_ff(wns), .rsp_stages_ff(stg));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // random address, shifted so that both sides of the width limits are hit
  function automatic logic [48:0] ra();
    logic [31:0] t;
    t = xs();
    return {t[16:0], xs()} >> t[20:17];
  endfunction

  task automatic final_report();
    if (n_mismatch == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic ck(input string nm, input logic [47:0] ex, input logic [47:0] got);
    checked++;
    if (got !== ex) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_mismatch++;
      final_report();
    end
  endtask

  // one transaction; the answer lands exactly one cycle after the device takes it
  task automatic tx(input logic [5:0] f, input logic [48:0] ad, input logic [2:0] ec);
    @(posedge clk);
    r = xs();
    d <= {r[7:0], f, ad};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    ck("rsp_valid", 48'h1, {47'h0, vld});
    ck("fault_code", {45'h0, ec}, {45'h0, code});
    ck("fault", {47'h0, ec != 3'h0}, {47'h0, flt});
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    ck("size_id", {25'h0, 3'h5, 2'h3, 6'h28, 6'h28, 6'h31}, {16'h0, r});
    apb(1'b0, 12'h010, 32'h0);
    ck("tcr_reset", 48'h0c0, {16'h0, r});
    apb(1'b0, 12'h020, 32'h0);
    ck("pslverr", 48'h1, {47'h0, e});
    r = xs();
    cb = r[15:0];
    apb(1'b1, 12'h00c, {16'h0, cb});
    apb(1'b1, 12'h004, 32'h0e0);
    for (int i = 0; i < 40; i++) begin
      a = ra();
      if (i < 2) a = 49'h0ffffffffff + 49'(i);
      tx(6'h00, a, (a[48:40] != 0) ? 3'h5 : 3'h0);
      ck("addr", (a[48:40] != 0) ? 48'h0 : a[47:0], addr);
      ck("attr", {40'h0, cb[7:0]}, {40'h0, attr});
      ck("mcid", {40'h0, cb[15:8]}, {40'h0, mcid});
      ck("stages", 48'h1, {46'h0, stg});
    end
    apb(1'b1, 12'h010, 32'h090);
    apb(1'b1, 12'h004, 32'h0e2);
    for (int i = 0; i < 30; i++) begin
      a = ra();
      if (i < 2) a = 49'h00fffffffff + 49'(i);
      tx(6'h00, a, (a[48:40] != 0) ? 3'h5 : (a[39:36] != 0) ? 3'h6 : 3'h0);
      ck("stages", 48'h2, {46'h0, stg});
    end
    apb(1'b1, 12'h004, 32'h0e3);
    repeat (10) begin
      a = ra();
      tx(6'h00, a, 3'h0);
      ck("bypass_addr", {8'h0, a[39:0]}, addr);
    end
    apb(1'b1, 12'h004, 32'h000);
    tx(6'h30, 49'h1000, 3'h1);
    apb(1'b1, 12'h004, 32'h080);
    tx(6'h30, 49'h1000, 3'h0);
    apb(1'b1, 12'h004, 32'h1e8);
    tx(6'h05, 49'h2000, 3'h7);
    apb(1'b1, 12'h008, 32'h1);
    tx(6'h05, 49'h2000, 3'h0);
    ck("instr", 48'h0, {47'h0, ins});
    apb(1'b0, 12'h01c, 32'h0);
    ck("secure_before", 48'h1, {47'h0, |(r[6:3] & r[10:7])});
    apb(1'b1, 12'h018, 32'h1);
    apb(1'b0, 12'h01c, 32'h0);
    ck("secure_entries", 48'h0, {44'h0, r[6:3] & r[10:7]});
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h010, 32'h0c1);
    apb(1'b1, 12'h004, 32'h0e4);
    tx(6'h00, 49'h3000, 3'h3);
    ck("hyp_mcid", 48'h0, {40'h0, mcid});
    tx(6'h00, 49'h1000000003000, 3'h5);
    apb(1'b1, 12'h010, 32'h0c0);
    apb(1'b1, 12'h014, 32'h61);
    apb(1'b1, 12'h004, 32'h0ec);
    tx(6'h08, 49'h3000, 3'h0);
    ck("walk_ns", 48'h1, {47'h0, wns});
    apb(1'b1, 12'h014, 32'h60);
    tx(6'h08, 49'h3000, 3'h0);
    ck("walk_ns", 48'h0, {47'h0, wns});
    apb(1'b1, 12'h004, 32'h0d0);
    apb(1'b1, 12'h008, 32'h6);
    tx(6'h00, 49'h4000, 3'h0);
    ck("transient", 48'h1, {47'h0, trn});
    apb(1'b1, 12'h008, 32'h2);
    tx(6'h02, 49'h4000, 3'h0);
    ck("transient", 48'h0, {47'h0, trn});
    tx(6'h00, 49'h100000000, 3'h2);
    apb(1'b1, 12'h010, 32'h1c0);
    tx(6'h00, 49'h4000, 3'h4);
    final_report();
  end
endmodule
`default_nettype wire
